// file: shared/fault_prot_defines.vh
// Constants for the drive fault-protection supervisor.
// Assumes a 100 MHz clock and the plain register port of the top module.
`ifndef FAULT_PROT_DEFINES_VH
`define FAULT_PROT_DEFINES_VH

// Register word addresses
`define A_CTRL 4'h0
`define A_ENABLE 4'h1
`define A_STATUS 4'h2
`define A_CLEAR 4'h3
`define A_OVSPD 4'h4
`define A_SPDWIN 4'h5
`define A_SPDTIME 4'h6
`define A_POSWIN 4'h7
`define A_POSTIME 4'h8
`define A_IPEAK 4'h9
`define A_ICONT 4'hA
`define A_I2TTIME 4'hB
`define A_BRON 4'hC
`define A_BROFF 4'hD
`define A_BUSLIM 4'hE
`define A_LIVE 4'hF

// Fault bit positions in the status word
`define F_HW 0
`define F_SW 1
`define F_CFG 2
`define F_OVC 3
`define F_BRPWR 4
`define F_OVV 5
`define F_UNV 6
`define F_DOT 7
`define F_HALL 8
`define F_ENC 9
`define F_IDX 10
`define F_MOT 11
`define F_OSPD 12
`define F_SPD 13
`define F_POS 14
`define NFAULT 15

// Control word fields
`define C_DRV_EN 0
`define C_MTYPE_LO 1
`define C_MTYPE_HI 2
`define MT_BLDC 2'h0
`define MT_PMDC 2'h1
`define MT_STEP 2'h2

// Enable-word bits (user-configurable protections)
`define E_HALL 0
`define E_ENC 1
`define E_IDX 2
`define E_MOT 3
`define E_OSPD 4
`define E_CTRL 5

// Rated limits and reset values
`define I_RATED 16'h0FA0
`define BR_MAX_US 32'h3D090
`define BR_MAX_CYC (`BR_MAX_US * 100)
`define RST_OVSPD 16'h14B4
`define RST_I2T 32'h0BEBC200
`define RST_BRON 16'h0348
`define RST_BROFF 16'h0334
`define RST_VMAX 16'h0370
`define RST_VMIN 16'h0064
`define CPR 16'h0FA0

`endif

// file: rtl/drive_fault_protection.v
// Fault-protection supervisor: trips, latches faults, disables the power stage.
// Assumes one 100 MHz clock; pin sensors are synchronised here, value inputs are not.
`timescale 1ns/1ps
`default_nettype none
`include "fault_prot_defines.vh"

// Register port: one-cycle strobes, read data one cycle later
// Pin-level faults cost two sync cycles before they can latch
// Value inputs arrive on this clock and are used as they stand
// Settings stay writable only while the drive is off

module drive_fault_protection (
    input wire I_REF_CLK,
    input wire I_SYS_RST,
    input wire [3:0] I_ADDR,
    input wire [31:0] I_WDATA,
    input wire I_WR,
    input wire I_RD,
    output reg [31:0] O_RDATA,
    input wire [2:0] I_HALL,
    input wire I_ENC_INDEX,
    input wire I_OVC,
    input wire I_DRV_OT,
    input wire I_MOT_OT,
    input wire I_HW_ERR,
    input wire I_SW_ERR,
    input wire [15:0] I_BUS_V,
    input wire [15:0] I_SPEED,
    input wire [15:0] I_SPEED_CMD,
    input wire [31:0] I_POS,
    input wire [31:0] I_POS_CMD,
    input wire [15:0] I_CUR_REQ,
    output reg [15:0] O_CUR_LIMIT,
    output reg O_DRV_EN,
    output reg O_FAULT,
    output reg O_BRAKE_RES
);

    // Absolute difference, used for speed and position windows
    function [31:0] absdiff;
        input [31:0] a;
        input [31:0] b;
        begin
            absdiff = ($signed(a) > $signed(b)) ? a - b : b - a;
        end
    endfunction

    // Limit a requested current to the rated maximum
    function [15:0] clamp_rated;
        input [15:0] v;
        begin
            clamp_rated = (v > `I_RATED) ? `I_RATED : v;
        end
    endfunction

    // Hall code to electrical sector, 3'h7 marks an illegal code
    function [2:0] hall_sector;
        input [2:0] h;
        begin
            case (h)
                3'h1: hall_sector = 3'h0;
                3'h3: hall_sector = 3'h1;
                3'h2: hall_sector = 3'h2;
                3'h6: hall_sector = 3'h3;
                3'h4: hall_sector = 3'h4;
                3'h5: hall_sector = 3'h5;
                default: hall_sector = 3'h7;
            endcase
        end
    endfunction

    reg [2:0] ctrl_q;
    reg [5:0] en_q;
    reg [`NFAULT-1:0] flt_q;
    reg [15:0] ovspd_q, spdwin_q, ipeak_q, icont_q, bron_q, broff_q, vmax_q, vmin_q;
    reg [31:0] spdtime_q, poswin_q, postime_q, i2ttime_q;

    // Two-flop synchronisers for pin inputs
    // Third stage only remembers the last hall code for transitions
    // Costs two cycles of reaction; a glitch shorter than one cycle may be lost
    reg [7:0] s1_q, s2_q;
    reg [7:0] s3_q;
    always @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            s1_q <= 8'h00;
            s2_q <= 8'h00;
            s3_q <= 8'h00;
        end else begin
            s1_q <= {I_SW_ERR, I_HW_ERR, I_MOT_OT, I_DRV_OT, I_OVC, I_HALL};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    wire [2:0] hall = s2_q[2:0];
    wire [2:0] hall_prev = s3_q[2:0];
    wire ovc = s2_q[3];
    wire dot = s2_q[4];
    wire mot = s2_q[5];
    wire hwe = s2_q[6];
    wire swe = s2_q[7];

    // Index pin synchroniser and rising-edge detector
    // Reset to low so a high pin at start reads as a real edge
    reg [1:0] idx_s_q;
    reg idx_prev_q;
    always @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            idx_s_q <= 2'h0;
            idx_prev_q <= 1'b0;
        end else begin
            idx_s_q <= {idx_s_q[0], I_ENC_INDEX};
            idx_prev_q <= idx_s_q[1];
        end
    end
    wire idx_rise = idx_s_q[1] & ~idx_prev_q;

    wire [1:0] mtype = ctrl_q[`C_MTYPE_HI:`C_MTYPE_LO];
    wire hall_motor = (mtype == `MT_BLDC);

    // Hall code and transition check: adjacent sectors only
    // Step of 1 or 5 means one sector either way; 0 means no change
    // Skipped sectors point to a broken or noisy sensor line
    wire [2:0] sec_now = hall_sector(hall);
    wire [2:0] sec_old = hall_sector(hall_prev);
    wire [2:0] sec_step = (sec_now >= sec_old) ? sec_now - sec_old : 3'h6 - (sec_old - sec_now);
    wire hall_bad = (sec_now == 3'h7) ||
        ((hall != hall_prev) && (sec_old != 3'h7) && sec_step != 3'h1 && sec_step != 3'h5);
    wire hall_trip = en_q[`E_HALL] & hall_motor & hall_bad;

    // Encoder sector from position, compared with hall sector
    // One sector of lead allowed, since hall arrives two cycles late
    wire [31:0] pos_mod = I_POS % {16'h0000, `CPR};
    wire [31:0] enc_sec_w = (pos_mod * 32'h6) / {16'h0000, `CPR};
    wire [2:0] enc_sec = enc_sec_w[2:0];
    wire enc_trip = en_q[`E_ENC] & hall_motor & (sec_now != 3'h7) &
        (enc_sec != sec_now) & (enc_sec != sec_now + 3'h1) &
        !(enc_sec == 3'h0 && sec_now == 3'h5);

    // Index must land where position count wraps
    // Either side of the wrap is accepted to absorb one count of skew
    wire idx_trip = en_q[`E_IDX] & idx_rise & (pos_mod != 32'h0) &
        (pos_mod != {16'h0000, `CPR} - 32'h1);

    // Overspeed on magnitude, either direction of rotation
    wire ospd_trip = en_q[`E_OSPD] & (absdiff({{16{I_SPEED[15]}}, I_SPEED}, 32'h0) >
        {16'h0000, ovspd_q});

    // Dwell counters for tracking windows; one enable gates both
    // Counters saturate so a long excursion never wraps back to zero
    reg [31:0] spd_cnt_q, pos_cnt_q;
    wire spd_out = absdiff({{16{I_SPEED[15]}}, I_SPEED},
        {{16{I_SPEED_CMD[15]}}, I_SPEED_CMD}) > {16'h0000, spdwin_q};
    wire pos_out = absdiff(I_POS, I_POS_CMD) > poswin_q;
    always @(posedge I_REF_CLK) begin
        if (I_SYS_RST || !en_q[`E_CTRL]) begin
            spd_cnt_q <= 32'h0;
            pos_cnt_q <= 32'h0;
        end else begin
            spd_cnt_q <= spd_out ? ((spd_cnt_q == 32'hFFFFFFFF) ? spd_cnt_q : spd_cnt_q + 32'h1)
                : 32'h0;
            pos_cnt_q <= pos_out ? ((pos_cnt_q == 32'hFFFFFFFF) ? pos_cnt_q : pos_cnt_q + 32'h1)
                : 32'h0;
        end
    end
    wire spd_trip = en_q[`E_CTRL] & spd_out & (spd_cnt_q >= spdtime_q);
    wire pos_trip = en_q[`E_CTRL] & pos_out & (pos_cnt_q >= postime_q);

    // Brake resistor hysteresis and on-time watchdog
    // On threshold checked first, so a bad pair leaves the resistor on
    // Watchdog count restarts every time the resistor turns off
    reg br_q;
    reg [31:0] br_cnt_q;
    always @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            br_q <= 1'b0;
            br_cnt_q <= 32'h0;
        end else begin
            if (I_BUS_V >= bron_q) begin
                br_q <= 1'b1;
            end else if (I_BUS_V <= broff_q) begin
                br_q <= 1'b0;
            end
            br_cnt_q <= br_q ? ((br_cnt_q == `BR_MAX_CYC) ? br_cnt_q : br_cnt_q + 32'h1) : 32'h0;
        end
    end
    wire br_trip = br_q & (br_cnt_q >= `BR_MAX_CYC);

    // I2T: peak allowed while the budget lasts, then continuous
    // Linear budget, not a true square law; cheaper and conservative enough
    reg [31:0] i2t_cnt_q;
    wire [15:0] ipk = clamp_rated(ipeak_q);
    wire [15:0] icn = clamp_rated(icont_q);
    wire above_cont = I_CUR_REQ > icn;
    wire peak_spent = i2t_cnt_q >= i2ttime_q;
    always @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            i2t_cnt_q <= 32'h0;
        end else if (above_cont) begin
            i2t_cnt_q <= peak_spent ? i2t_cnt_q : i2t_cnt_q + 32'h1;
        end else if (i2t_cnt_q != 32'h0) begin
            i2t_cnt_q <= i2t_cnt_q - 32'h1; // Recover budget while below continuous
        end
    end

    // Configuration checks: bad ranges, or write while enabled
    // Range faults persist until the offending setting is fixed
    wire is_cfg_addr = (I_ADDR >= `A_OVSPD) && (I_ADDR <= `A_BUSLIM);
    wire cfg_bad = (broff_q >= bron_q) || (vmin_q >= vmax_q) || (icont_q > ipeak_q) ||
        (mtype == 2'h3);
    wire cfg_trip = cfg_bad | (I_WR & is_cfg_addr & ctrl_q[`C_DRV_EN]);

    reg [`NFAULT-1:0] trip;
    always @* begin
        trip = {`NFAULT{1'b0}};
        trip[`F_HW] = hwe;
        trip[`F_SW] = swe;
        trip[`F_CFG] = cfg_trip;
        trip[`F_OVC] = ovc;
        trip[`F_BRPWR] = br_trip;
        trip[`F_OVV] = I_BUS_V > vmax_q;
        trip[`F_UNV] = I_BUS_V < vmin_q;
        trip[`F_DOT] = dot;
        trip[`F_HALL] = hall_trip;
        trip[`F_ENC] = enc_trip;
        trip[`F_IDX] = idx_trip;
        trip[`F_MOT] = en_q[`E_MOT] & mot;
        trip[`F_OSPD] = ospd_trip;
        trip[`F_SPD] = spd_trip;
        trip[`F_POS] = pos_trip;
    end

    // Register writes and sticky faults; a new trip beats a clear
    // Enable bit drops on its own while any fault is latched
    always @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            ctrl_q <= 3'h0;
            en_q <= 6'h00;
            flt_q <= {`NFAULT{1'b0}};
            ovspd_q <= `RST_OVSPD;
            spdwin_q <= 16'h0000;
            spdtime_q <= 32'h0;
            poswin_q <= 32'h0;
            postime_q <= 32'h0;
            ipeak_q <= `I_RATED;
            icont_q <= `I_RATED;
            i2ttime_q <= `RST_I2T;
            bron_q <= `RST_BRON;
            broff_q <= `RST_BROFF;
            vmax_q <= `RST_VMAX;
            vmin_q <= `RST_VMIN;
        end else begin
            if (I_WR && !ctrl_q[`C_DRV_EN]) begin
                // Settings locked while enabled
                case (I_ADDR)
                    `A_ENABLE: en_q <= I_WDATA[5:0];
                    `A_OVSPD: ovspd_q <= I_WDATA[15:0];
                    `A_SPDWIN: spdwin_q <= I_WDATA[15:0];
                    `A_SPDTIME: spdtime_q <= I_WDATA;
                    `A_POSWIN: poswin_q <= I_WDATA;
                    `A_POSTIME: postime_q <= I_WDATA;
                    `A_IPEAK: ipeak_q <= I_WDATA[15:0];
                    `A_ICONT: icont_q <= I_WDATA[15:0];
                    `A_I2TTIME: i2ttime_q <= I_WDATA;
                    `A_BRON: bron_q <= I_WDATA[15:0];
                    `A_BROFF: broff_q <= I_WDATA[15:0];
                    `A_BUSLIM: begin
                        vmax_q <= I_WDATA[31:16];
                        vmin_q <= I_WDATA[15:0];
                    end
                    default: ;
                endcase
            end
            if (I_WR && I_ADDR == `A_CTRL) begin
                ctrl_q <= I_WDATA[2:0];
            end else if (|flt_q) begin
                ctrl_q[`C_DRV_EN] <= 1'b0;
            end
            if (I_WR && I_ADDR == `A_CLEAR) begin
                flt_q <= (flt_q & ~I_WDATA[`NFAULT-1:0]) | trip;
            end else begin
                flt_q <= flt_q | trip;
            end
        end
    end

    // Outputs from flops; drive held off while any fault is latched
    // Live trip also gates the enable, saving one cycle of exposure
    // Read data is zero outside the slot after a read strobe
    always @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            O_DRV_EN <= 1'b0;
            O_FAULT <= 1'b0;
            O_BRAKE_RES <= 1'b0;
            O_CUR_LIMIT <= 16'h0000;
            O_RDATA <= 32'h0;
        end else begin
            O_DRV_EN <= ctrl_q[`C_DRV_EN] & ~(|flt_q) & ~(|trip);
            O_FAULT <= |flt_q;
            O_BRAKE_RES <= br_q;
            O_CUR_LIMIT <= peak_spent ? icn : ipk;
            O_RDATA <= 32'h0;
            if (I_RD) begin
                case (I_ADDR)
                    `A_CTRL: O_RDATA <= {29'h0, ctrl_q};
                    `A_ENABLE: O_RDATA <= {26'h0, en_q};
                    `A_STATUS: O_RDATA <= {17'h0, flt_q};
                    `A_OVSPD: O_RDATA <= {16'h0, ovspd_q};
                    `A_SPDWIN: O_RDATA <= {16'h0, spdwin_q};
                    `A_SPDTIME: O_RDATA <= spdtime_q;
                    `A_POSWIN: O_RDATA <= poswin_q;
                    `A_POSTIME: O_RDATA <= postime_q;
                    `A_IPEAK: O_RDATA <= {16'h0, ipk};
                    `A_ICONT: O_RDATA <= {16'h0, icn};
                    `A_I2TTIME: O_RDATA <= i2ttime_q;
                    `A_BRON: O_RDATA <= {16'h0, bron_q};
                    `A_BROFF: O_RDATA <= {16'h0, broff_q};
                    `A_BUSLIM: O_RDATA <= {vmax_q, vmin_q};
                    `A_LIVE: O_RDATA <= {29'h0, peak_spent, br_q, |flt_q};
                    default: O_RDATA <= 32'h0;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// file: testbench/drive_fault_protection_checker.sv
// Port-level checker for the fault supervisor, attached by bind.
// Assumes brake and bus limits keep their reset values during the run.
`timescale 1ns/1ps
`default_nettype none
`include "fault_prot_defines.vh"
module fault_prot_checker (
    input wire logic I_REF_CLK,
    input wire logic I_SYS_RST,
    input wire logic [3:0] I_ADDR,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [31:0] O_RDATA,
    input wire logic I_OVC,
    input wire logic I_DRV_OT,
    input wire logic [15:0] I_BUS_V,
    input wire logic [15:0] O_CUR_LIMIT,
    input wire logic O_DRV_EN,
    input wire logic O_FAULT,
    input wire logic O_BRAKE_RES
);
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_SYS_RST);
    // Any clear write, whatever the data, may release the latch
    wire logic clr = I_WR && (I_ADDR == `A_CLEAR);
    property p_fault_off; O_FAULT |=> !O_DRV_EN; endproperty
    a_fault_off: assert property (p_fault_off) else $error("drive on with fault");
    property p_rd_idle; !I_RD |=> O_RDATA == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_ovc; $rose(I_OVC) |-> ##[2:4] O_FAULT; endproperty
    a_ovc: assert property (p_ovc) else $error("overcurrent not flagged");
    property p_dot; $rose(I_DRV_OT) |-> ##[2:4] O_FAULT; endproperty
    a_dot: assert property (p_dot) else $error("overtemperature not flagged");
    property p_ovv; I_BUS_V > 16'h0370 |-> ##[1:2] O_FAULT; endproperty
    a_ovv: assert property (p_ovv) else $error("overvoltage not flagged");
    property p_unv; I_BUS_V < 16'h0064 |-> ##[1:2] O_FAULT; endproperty
    a_unv: assert property (p_unv) else $error("undervoltage not flagged");
    property p_br_on; $rose(O_BRAKE_RES) |-> $past(I_BUS_V, 2) >= 16'h0348; endproperty
    a_br_on: assert property (p_br_on) else $error("brake on too low");
    property p_br_off; $fell(O_BRAKE_RES) |-> $past(I_BUS_V, 2) <= 16'h0334; endproperty
    a_br_off: assert property (p_br_off) else $error("brake off too high");
    property p_lim; O_CUR_LIMIT <= 16'h0FA0; endproperty
    a_lim: assert property (p_lim) else $error("limit above rating");
    property p_hold; O_FAULT && !clr && !$past(clr) |=> O_FAULT; endproperty
    a_hold: assert property (p_hold) else $error("fault dropped uncleared");
    c_trip: cover property ($rose(O_FAULT));
    c_brake: cover property ($fell(O_BRAKE_RES));
    c_drop: cover property ($fell(O_DRV_EN));
endmodule
bind drive_fault_protection fault_prot_checker u_chk (
    .I_REF_CLK(I_REF_CLK), .I_SYS_RST(I_SYS_RST), .I_ADDR(I_ADDR), .I_WR(I_WR),
    .I_RD(I_RD), .O_RDATA(O_RDATA), .I_OVC(I_OVC), .I_DRV_OT(I_DRV_OT),
    .I_BUS_V(I_BUS_V), .O_CUR_LIMIT(O_CUR_LIMIT), .O_DRV_EN(O_DRV_EN),
    .O_FAULT(O_FAULT), .O_BRAKE_RES(O_BRAKE_RES)
);
`default_nettype wire

// file: testbench/motor_model.sv
// Motor far side: hall code, index and encoder count from one shaft count.
// Assumes steps come slowly enough for the pin synchronisers to follow.
`timescale 1ns/1ps
`default_nettype none
module motor_model (
    input wire logic clk,
    input wire logic step,
    input wire logic bad,
    output logic [2:0] hall,
    output logic idx,
    output logic [31:0] pos
);
    // Sector codes 0..5, lowest sector in the low bits
    localparam logic [17:0] TBL = {3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
    logic [31:0] sect;
    initial pos = 32'h0;
    // One count per step
    always @(posedge clk) begin
        if (step) begin
            pos <= pos + 32'h1;
        end
    end
    // Hall tracks the sector; bad gives a code no sensor can show
    always @* begin
        sect = ((pos % 32'hFA0) * 32'h6) / 32'hFA0;
        hall = bad ? 3'h7 : TBL[sect * 3 +: 3];
        idx = (pos % 32'hFA0) == 32'h0;
    end
endmodule
`default_nettype wire

// file: testbench/drive_fault_protection_tb.sv
// Bench for the fault supervisor: register tasks, pin faults, motor model.
// Assumes brake and bus limits stay at reset values.
`timescale 1ns/1ps
`default_nettype none
`include "fault_prot_defines.vh"
module drive_fault_protection_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic step = 1'b0;
    logic bad = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [4:0] pin = 5'h0;
    logic [15:0] bus_v = 16'h0200;
    logic [15:0] speed = 16'h0;
    logic [15:0] speed_cmd = 16'h0;
    logic [15:0] cur_req = 16'h0;
    logic [31:0] pos_cmd = 32'h0;
    wire [31:0] rdata;
    wire [31:0] pos;
    wire [15:0] cur_lim;
    wire [2:0] hall;
    wire idx, drv_en, fault, brake;
    wire [31:0] outs = {29'h0, drv_en, fault, brake};
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;
    int fb[5] = '{3, 7, 11, 0, 1};
    logic [15:0] bv[6] = '{16'h0347, 16'h0348, 16'h0335, 16'h0334, 16'h0370, 16'h0064};
    logic [31:0] be[6] = '{32'h0, 32'h1, 32'h1, 32'h0, 32'h1, 32'h0};
    int ln[4] = '{30, 15, 30, 30};
    logic [31:0] te[4] = '{32'h0, 32'h0, 32'h2000, 32'h4000};
    drive_fault_protection uut (
        .I_REF_CLK(clk), .I_SYS_RST(rst), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_HALL(hall), .I_ENC_INDEX(idx),
        .I_OVC(pin[0]), .I_DRV_OT(pin[1]), .I_MOT_OT(pin[2]), .I_HW_ERR(pin[3]),
        .I_SW_ERR(pin[4]), .I_BUS_V(bus_v), .I_SPEED(speed), .I_SPEED_CMD(speed_cmd),
        .I_POS(pos), .I_POS_CMD(pos_cmd), .I_CUR_REQ(cur_req), .O_CUR_LIMIT(cur_lim),
        .O_DRV_EN(drv_en), .O_FAULT(fault), .O_BRAKE_RES(brake)
    );
    motor_model motor (.clk(clk), .step(step), .bad(bad), .hall(hall), .idx(idx), .pos(pos));
    always #5 clk = ~clk;
    task automatic stop_test();
        $display("fails %0d checks %0d", n_fail, samples_checked);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Hang guard well above the motor sweep length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 50000) begin
            n_fail = n_fail + 1;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Data stands only in the cycle after the strobe
    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rchk(`A_STATUS, 32'h0);
        rchk(`A_OVSPD, 32'h14B4);
        rchk(`A_BUSLIM, 32'h03700064);
        rchk(`A_BRON, 32'h0348);
        rchk(`A_BROFF, 32'h0334);
        $display("test reset done");
        wreg(`A_ENABLE, 32'h8);
        for (int i = 0; i < 5; i++) begin
            wreg(`A_CTRL, 32'h1);
            repeat (3) @(posedge clk);
            #1 chk(outs, 32'h4);
            pin[i] <= 1'b1;
            repeat (6) @(posedge clk);
            pin[i] <= 1'b0;
            #1 chk(outs, 32'h2);
            rchk(`A_STATUS, 32'h1 << fb[i]);
            rchk(`A_CTRL, 32'h0);
            wreg(`A_CLEAR, 32'h7FFF);
            rchk(`A_STATUS, 32'h0);
        end
        $display("test pin faults done");
        for (int i = 0; i < 6; i++) begin
            bus_v <= bv[i];
            repeat (3) @(posedge clk);
            #1 chk(outs, be[i]);
        end
        rchk(`A_STATUS, 32'h0);
        for (int i = 0; i < 2; i++) begin
            bus_v <= (i == 0) ? 16'h0371 : 16'h0063;
            repeat (3) @(posedge clk);
            bus_v <= 16'h0200;
            rchk(`A_STATUS, 32'h20 << i);
            wreg(`A_CLEAR, 32'h7FFF);
        end
        $display("test bus done");
        wreg(`A_CTRL, 32'h1);
        wreg(`A_OVSPD, 32'h1000);
        rchk(`A_STATUS, 32'h4);
        rchk(`A_OVSPD, 32'h14B4);
        wreg(`A_CLEAR, 32'h7FFF);
        wreg(`A_CTRL, 32'h6);
        rchk(`A_STATUS, 32'h4);
        wreg(`A_CTRL, 32'h0);
        wreg(`A_CLEAR, 32'h7FFF);
        $display("test config done");
        wreg(`A_ENABLE, 32'h10);
        speed <= 16'h14B4;
        rchk(`A_STATUS, 32'h0);
        speed <= 16'h14B5;
        rchk(`A_STATUS, 32'h1000);
        speed <= 16'h0;
        wreg(`A_CLEAR, 32'h7FFF);
        wreg(`A_SPDWIN, 32'hA);
        wreg(`A_SPDTIME, 32'h14);
        wreg(`A_POSWIN, 32'hA);
        wreg(`A_POSTIME, 32'h14);
        for (int i = 0; i < 4; i++) begin
            wreg(`A_ENABLE, (i > 0) ? 32'h20 : 32'h0);
            speed <= (i == 3) ? 16'h0 : 16'h32;
            pos_cmd <= (i == 3) ? 32'h32 : 32'h0;
            repeat (ln[i]) @(posedge clk);
            speed <= 16'h0;
            pos_cmd <= 32'h0;
            rchk(`A_STATUS, te[i]);
            wreg(`A_CLEAR, 32'h7FFF);
        end
        speed <= 16'h32;
        speed_cmd <= 16'h30;
        repeat (30) @(posedge clk);
        rchk(`A_STATUS, 32'h0);
        speed <= 16'h0;
        speed_cmd <= 16'h0;
        $display("test tracking done");
        wreg(`A_ICONT, 32'h100);
        wreg(`A_I2TTIME, 32'h32);
        wreg(`A_IPEAK, 32'hFFFF);
        cur_req <= 16'h0800;
        repeat (10) @(posedge clk);
        #1 chk({16'h0, cur_lim}, 32'h0FA0);
        repeat (60) @(posedge clk);
        #1 chk({16'h0, cur_lim}, 32'h0100);
        rchk(`A_LIVE, 32'h4);
        cur_req <= 16'h0;
        $display("test current limit done");
        wreg(`A_ENABLE, 32'h7);
        repeat (4005) begin
            step <= 1'b1;
            @(posedge clk);
            step <= 1'b0;
            repeat (7) @(posedge clk);
        end
        rchk(`A_STATUS, 32'h0);
        wreg(`A_ENABLE, 32'h1);
        bad <= 1'b1;
        repeat (3) @(posedge clk);
        rchk(`A_STATUS, 32'h100);
        wreg(`A_CTRL, 32'h2);
        wreg(`A_CLEAR, 32'h7FFF);
        rchk(`A_STATUS, 32'h0);
        bad <= 1'b0;
        $display("test motor done");
        stop_test();
    end
endmodule
`default_nettype wire
